//--- core/pmg_defines.vh
// constants for the peripheral module gating block
`ifndef PMG_DEFINES_VH
`define PMG_DEFINES_VH
`define PMG_NUM_MODULES 20
`define PMG_IDX_W 5
`define PMG_DATA_W 8
`define PMG_GATE0_LSB 0
`define PMG_GATE0_W 8
`define PMG_GATE1_LSB 8
`define PMG_GATE1_W 8
`define PMG_GATE2_LSB 16
`define PMG_GATE2_W 4
`define PMG_GATE0_RST 8'h00
`define PMG_GATE1_RST 8'h00
`define PMG_GATE2_RST 4'h0
`define PMG_SEL_GATE0 2'h0
`define PMG_SEL_GATE1 2'h1
`define PMG_SEL_GATE2 2'h2
`define PMG_CTRL_RST 8'h00
`define PMG_FUNC_EN_BIT 7
`define PMG_INVALID_DATA 8'h00
`endif

//--- core/periph_slot.v
// one peripheral's control register with enable and gate handling
`timescale 1ns/1ps
`default_nettype none
`include "pmg_defines.vh"
module periph_slot (
	input wire clk,
	input wire arst_n,
	input wire sys_rst,
	input wire gated,
	input wire wr,
	input wire [`PMG_DATA_W-1:0] wdata,
	output reg [`PMG_DATA_W-1:0] ctrl_q,
	output reg run_q
);
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= `PMG_CTRL_RST;
			run_q <= 1'b0;
		end else if (sys_rst) begin
			ctrl_q <= `PMG_CTRL_RST;
			run_q <= 1'b0;
		end else begin
			if (wr && !gated) begin
				ctrl_q <= wdata;
			end
			// run needs enable and no gate
			run_q <= ctrl_q[`PMG_FUNC_EN_BIT] & ~gated;
		end
	end
endmodule // periph_slot
`default_nettype wire

//--- core/peripheral_module_gating.v
// per-peripheral functional enable and clock gating control
`timescale 1ns/1ps
`default_nettype none
`include "pmg_defines.vh"
// Function
// - clearing a module's enable stops its function but its registers stay readable and writable.
// - setting a module's gate bit removes every clock feeding that module.
// - while gated, writes to the module's registers are ignored and contents kept.
// - while gated, reads of the module's registers return data that must not be relied on.
// - there are three gating registers, each bit gating one particular peripheral.
// - the enable bit sits in the module's control register and the gate bit in a gating register, independently.
// - power-on or brown-out reset clears the first and second gating registers' eight bits and the third's four bits.
// - pin, watchdog, instruction and stack resets clear all three gating registers too.
// - a wake-up from a low-power state leaves the gating registers unchanged.
module peripheral_module_gating (
	input wire clk,
	input wire arst_n,
	input wire por_bor_rst,
	input wire external_reset_pin_rst,
	input wire watchdog_timer_rst,
	input wire instr_rst,
	input wire stack_rst,
	input wire gate_wr,
	input wire [1:0] gate_sel,
	input wire [`PMG_DATA_W-1:0] gate_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [`PMG_IDX_W-1:0] reg_idx,
	input wire [`PMG_DATA_W-1:0] reg_wdata,
	output reg [`PMG_DATA_W-1:0] reg_rdata,
	output reg reg_rvalid,
	output reg [`PMG_DATA_W-1:0] gate_rdata,
	output reg [`PMG_NUM_MODULES-1:0] module_clk_en,
	output reg [`PMG_NUM_MODULES-1:0] module_run
);
	////////////////////////////////////////////////////////////////////////////////
	// reset causes and decode
	wire sys_rst;
	wire por_clear;
	wire warm_clear;
	reg [`PMG_NUM_MODULES-1:0] module_clock_gate_q;
	reg [`PMG_NUM_MODULES-1:0] module_clock_gate_d;
	wire [`PMG_NUM_MODULES-1:0] slot_run;
	wire [`PMG_NUM_MODULES-1:0] slot_wr;
	wire [`PMG_DATA_W*`PMG_NUM_MODULES-1:0] slot_ctrl;
	reg [`PMG_DATA_W-1:0] sel_ctrl;
	reg [`PMG_DATA_W-1:0] reg_rdata_d;
	reg [`PMG_DATA_W-1:0] gate_rdata_d;
	wire sel_gated;
	integer k;

	assign por_clear = por_bor_rst;
	assign warm_clear = external_reset_pin_rst | watchdog_timer_rst | instr_rst |
		stack_rst;
	assign sys_rst = por_clear | warm_clear;

	////////////////////////////////////////////////////////////////////////////////
	// helper functions
	function hit;
		input [`PMG_IDX_W-1:0] idx;
		input integer n;
		begin
			hit = (idx == n[`PMG_IDX_W-1:0]);
		end
	endfunction

	// gate bit of a mapped index, zero for unmapped indices
	function gated_at;
		input [`PMG_NUM_MODULES-1:0] gates;
		input [`PMG_IDX_W-1:0] idx;
		integer m;
		begin
			gated_at = 1'b0;
			for (m = 0; m < `PMG_NUM_MODULES; m = m + 1) begin
				if (hit(idx, m)) begin
					gated_at = gates[m];
				end
			end
		end
	endfunction

	// readback of one gating register, unimplemented bits read zero
	function [`PMG_DATA_W-1:0] gate_view;
		input [`PMG_NUM_MODULES-1:0] gates;
		input [1:0] sel;
		begin
			case (sel)
				`PMG_SEL_GATE0: begin
					gate_view = gates[`PMG_GATE0_LSB +: `PMG_GATE0_W];
				end
				`PMG_SEL_GATE1: begin
					gate_view = gates[`PMG_GATE1_LSB +: `PMG_GATE1_W];
				end
				`PMG_SEL_GATE2: begin
					gate_view = {{(`PMG_DATA_W-`PMG_GATE2_W){1'b0}},
						gates[`PMG_GATE2_LSB +: `PMG_GATE2_W]};
				end
				default: begin
					gate_view = `PMG_INVALID_DATA;
				end
			endcase
		end
	endfunction

	// gating register contents after a write to one of them
	function [`PMG_NUM_MODULES-1:0] gate_merge;
		input [`PMG_NUM_MODULES-1:0] gates;
		input [1:0] sel;
		input [`PMG_DATA_W-1:0] data;
		begin
			gate_merge = gates;
			case (sel)
				`PMG_SEL_GATE0: begin
					gate_merge[`PMG_GATE0_LSB +: `PMG_GATE0_W] = data;
				end
				`PMG_SEL_GATE1: begin
					gate_merge[`PMG_GATE1_LSB +: `PMG_GATE1_W] = data;
				end
				`PMG_SEL_GATE2: begin
					gate_merge[`PMG_GATE2_LSB +: `PMG_GATE2_W] = data[`PMG_GATE2_W-1:0];
				end
				default: begin
					gate_merge = gates;
				end
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// gating registers
	always @* begin
		module_clock_gate_d = module_clock_gate_q;
		if (sys_rst) begin
			module_clock_gate_d = {`PMG_GATE2_RST, `PMG_GATE1_RST, `PMG_GATE0_RST};
		end else if (gate_wr) begin
			module_clock_gate_d = gate_merge(module_clock_gate_q, gate_sel, gate_wdata);
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			module_clock_gate_q <= {`PMG_GATE2_RST, `PMG_GATE1_RST, `PMG_GATE0_RST};
		end else begin
			module_clock_gate_q <= module_clock_gate_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// peripheral slots
	genvar g;
	generate
		for (g = 0; g < `PMG_NUM_MODULES; g = g + 1) begin : gen_slot
			// one write strobe per slot
			assign slot_wr[g] = reg_wr & hit(reg_idx, g);
			periph_slot u_slot (
				.clk(clk),
				.arst_n(arst_n),
				.sys_rst(sys_rst),
				.gated(module_clock_gate_q[g]),
				.wr(slot_wr[g]),
				.wdata(reg_wdata),
				.ctrl_q(slot_ctrl[g*`PMG_DATA_W +: `PMG_DATA_W]),
				.run_q(slot_run[g])
			);
		end
	endgenerate

	always @* begin
		sel_ctrl = `PMG_INVALID_DATA;
		for (k = 0; k < `PMG_NUM_MODULES; k = k + 1) begin
			if (hit(reg_idx, k)) begin
				sel_ctrl = slot_ctrl[k*`PMG_DATA_W +: `PMG_DATA_W];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read paths
	assign sel_gated = gated_at(module_clock_gate_q, reg_idx);

	always @* begin
		reg_rdata_d = reg_rdata;
		if (reg_rd) begin
			if (sel_gated) begin
				reg_rdata_d = `PMG_INVALID_DATA;
			end else begin
				reg_rdata_d = sel_ctrl;
			end
		end
		gate_rdata_d = gate_view(module_clock_gate_q, gate_sel);
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= `PMG_INVALID_DATA;
			reg_rvalid <= 1'b0;
			gate_rdata <= `PMG_INVALID_DATA;
			module_clk_en <= {`PMG_NUM_MODULES{1'b1}};
			module_run <= {`PMG_NUM_MODULES{1'b0}};
		end else begin
			reg_rvalid <= reg_rd;
			reg_rdata <= reg_rdata_d;
			gate_rdata <= gate_rdata_d;

			module_clk_en <= ~module_clock_gate_q;
			module_run <= slot_run;
		end
	end
endmodule // peripheral_module_gating
`default_nettype wire

//--- bench/pmg_chk_asserts.sv
// gating checker
`timescale 1ns/1ps
`default_nettype none
module pmg_chk (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic por_bor_rst,
	input wire logic external_reset_pin_rst,
	input wire logic watchdog_timer_rst,
	input wire logic instr_rst,
	input wire logic stack_rst,
	input wire logic gate_wr,
	input wire logic reg_rd,
	input wire logic reg_rvalid,
	input wire logic [1:0] gate_sel,
	input wire logic [7:0] gate_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] gate_rdata,
	input wire logic [4:0] reg_idx,
	input wire logic [19:0] module_clk_en,
	input wire logic [19:0] module_run
);
wire rs = por_bor_rst | external_reset_pin_rst | watchdog_timer_rst | instr_rst | stack_rst;
default clocking @(posedge clk); endclocking
default disable iff (!arst_n);
property p_clk; gate_wr && gate_sel == 2'h1 && !rs ##1 !gate_wr && !rs
	|=> module_clk_en[15:8] == ~$past(gate_wdata, 2); endproperty
a_clk: assert property (p_clk) else $error("clock enable wrong");
property p_rst; rs |-> ##2 (&module_clk_en && module_run == 20'h0); endproperty
a_rst: assert property (p_rst) else $error("reset left gating");
property p_keep; !gate_wr && !rs |-> ##2 $stable(module_clk_en); endproperty
a_keep: assert property (p_keep) else $error("gating changed alone");
property p_run; (module_run & ~$past(module_clk_en)) == 20'h0; endproperty
a_run: assert property (p_run) else $error("gated module runs");
property p_rv; reg_rd |=> reg_rvalid; endproperty
a_rv: assert property (p_rv) else $error("no read valid");
property p_map; reg_rd && reg_idx > 5'd19 |=> reg_rdata == 8'h00; endproperty
a_map: assert property (p_map) else $error("unmapped read");
property p_hi; gate_sel == 2'h2 |=> gate_rdata[7:4] == 4'h0; endproperty
a_hi: assert property (p_hi) else $error("gate reg upper bits");
property p_none; gate_sel == 2'h3 |=> gate_rdata == 8'h00; endproperty
a_none: assert property (p_none) else $error("no gate reg read");
c_gw: cover property (gate_wr && gate_sel == 2'h0);
c_rs: cover property (rs);
c_rd: cover property (reg_rd && reg_idx == 5'd3);
endmodule // pmg_chk
bind peripheral_module_gating pmg_chk i_chk (
	.clk(clk),
	.arst_n(arst_n),
	.por_bor_rst(por_bor_rst),
	.external_reset_pin_rst(external_reset_pin_rst),
	.watchdog_timer_rst(watchdog_timer_rst),
	.instr_rst(instr_rst),
	.stack_rst(stack_rst),
	.gate_wr(gate_wr),
	.reg_rd(reg_rd),
	.reg_rvalid(reg_rvalid),
	.gate_sel(gate_sel),
	.gate_wdata(gate_wdata),
	.reg_rdata(reg_rdata),
	.gate_rdata(gate_rdata),
	.reg_idx(reg_idx),
	.module_clk_en(module_clk_en),
	.module_run(module_run)
);
`default_nettype wire

//--- bench/peripheral_module_gating_tb_top.sv
// gating bench
`timescale 1ns/1ps
`default_nettype none
module peripheral_module_gating_tb_top;
logic clk = 0, arst_n = 0, gate_wr = 0, reg_wr = 0, reg_rd = 0;
logic [1:0] gate_sel = '0;
logic [4:0] reg_idx = '0, rs = '0;
logic [7:0] gate_wdata = '0, reg_wdata = '0;
wire [7:0] reg_rdata, gate_rdata;
wire reg_rvalid;
wire [19:0] module_clk_en, module_run;
int bad_count = 0, samples_checked = 0, cyc_n = 0;
peripheral_module_gating i_dut (
	.clk(clk),
	.arst_n(arst_n),
	.por_bor_rst(rs[0]),
	.external_reset_pin_rst(rs[1]),
	.watchdog_timer_rst(rs[2]),
	.instr_rst(rs[3]),
	.stack_rst(rs[4]),
	.gate_wr(gate_wr),
	.gate_sel(gate_sel),
	.gate_wdata(gate_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_idx(reg_idx),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid),
	.gate_rdata(gate_rdata),
	.module_clk_en(module_clk_en),
	.module_run(module_run)
);
always #5 clk = ~clk;
always @(posedge clk) begin
	cyc_n <= cyc_n + 1;
	if (cyc_n == 1000) begin
		bad_count++;
		tally_and_finish();
	end
end
task tick(int n);
	repeat (n) @(posedge clk);
	#1;
endtask
task chk(logic [19:0] g, e);
	samples_checked++;
	if (g !== e) begin
		bad_count++;
		$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
	end
endtask
task gw(logic [1:0] s, logic [7:0] d);
	gate_wr = 1;
	gate_sel = s;
	gate_wdata = d;
	tick(1);
	gate_wr = 0;
	tick(3);
endtask
task rw(logic [4:0] i, logic [7:0] d);
	reg_wr = 1;
	reg_idx = i;
	reg_wdata = d;
	tick(1);
	reg_wr = 0;
	tick(3);
endtask
task rr(logic [4:0] i, logic [7:0] e);
	reg_rd = 1;
	reg_idx = i;
	tick(1);
	reg_rd = 0;
	chk(20'(reg_rvalid), 20'h00001);
	chk(20'(reg_rdata), 20'(e));
endtask
task rg(logic [4:0] i);
	reg_rd = 1;
	reg_idx = i;
	tick(1);
	reg_rd = 0;
	chk(20'(reg_rvalid), 20'h00001);
endtask
task t_enable;
	chk(module_clk_en, 20'hfffff);
	chk(module_run, 20'h00000);
	rw(5'h03, 8'h80);
	chk(module_run, 20'h00008);
	rr(5'h03, 8'h80);
	rw(5'h03, 8'h00);
	chk(module_run, 20'h00000);
	rr(5'h03, 8'h00);
	$display("t_enable done");
endtask
task t_gate;
	rw(5'h03, 8'h80);
	gw(2'h0, 8'h08);
	chk(module_clk_en, 20'hffff7);
	chk(module_run, 20'h00000);
	rw(5'h03, 8'h55);
	rg(5'h03);
	gw(2'h0, 8'h00);
	rr(5'h03, 8'h80);
	chk(module_run, 20'h00008);
	gw(2'h2, 8'hff);
	chk(20'(gate_rdata), 20'h0000f);
	gw(2'h3, 8'hff);
	chk(module_clk_en, 20'h0ffff);
	rr(5'h19, 8'h00);
	$display("t_gate done");
endtask
task t_rst;
	for (int i = 0; i < 5; i++) begin
		gw(2'h1, 8'hff);
		gw(2'h2, 8'h0f);
		tick(4);
		chk(module_clk_en, 20'h000ff);
		rs = 5'(1 << i);
		tick(1);
		rs = '0;
		tick(3);
		chk(module_clk_en, 20'hfffff);
		chk(20'(gate_rdata), 20'h0);
	end
	$display("t_rst done");
endtask
task tally_and_finish;
	$display("checked %0d mismatched %0d", samples_checked, bad_count);
	if (bad_count == 0 && samples_checked > 0)
		$display("No errors found");
	else
		$display("Errors were found");
	$finish;
endtask
initial begin
	tick(2);
	arst_n = 1;
	t_enable();
	t_gate();
	t_rst();
	tally_and_finish();
end
endmodule // peripheral_module_gating_tb_top
`default_nettype wire
